// file: port_c_pkg.sv
// Package with register map, reset values and field positions of the port C block
package port_c_pkg;

  // Register byte addresses on the Wishbone slave
  localparam logic [7:0] OFS_LATCH = 8'h00;
  localparam logic [7:0] OFS_DIRECTION = 8'h04;
  localparam logic [7:0] OFS_PIN_LEVEL = 8'h08;
  localparam logic [7:0] OFS_ANALOG_SEL = 8'h0C;
  localparam logic [7:0] OFS_ALT_CTRL = 8'h10;
  localparam logic [7:0] OFS_STATUS = 8'h14;

  // Port geometry
  localparam int PORT_WIDTH = 8;
  localparam int DATA_WIDTH = 32;
  localparam int ADDR_WIDTH = 8;

  // Reset values
  localparam logic [7:0] DIRECTION_RESET = 8'hFF;
  localparam logic [7:0] ANALOG_SEL_RESET = 8'hCF;
  localparam logic [7:0] ALT_CTRL_RESET = 8'h00;
  localparam logic [7:0] LATCH_RESET_DEFAULT = 8'h00;
  localparam logic [31:0] READ_ZERO = 32'h0000_0000;

  // Pin numbers of the alternate functions
  localparam int PIN_REF_HIGH = 0;
  localparam int PIN_REF_LOW = 1;
  localparam int PIN_PWM_D = 2;
  localparam int PIN_REF_OUT = 2;
  localparam int PIN_PWM_C = 3;
  localparam int PIN_PROG = 3;
  localparam int PIN_PWM_B = 4;
  localparam int PIN_CMP_OUT = 4;
  localparam int NUM_EXT_INT = 3;
  localparam int NUM_CONV_CH = 4;

  // Field positions in the alternate-function control register
  localparam int ALT_CMP_OUT_EN = 0;
  localparam int ALT_PWM_B_EN = 1;
  localparam int ALT_PWM_C_EN = 2;
  localparam int ALT_PWM_D_EN = 3;
  localparam int ALT_SHDN_TRI_B = 4;
  localparam int ALT_SHDN_TRI_C = 5;
  localparam int ALT_SHDN_TRI_D = 6;
  localparam int ALT_REF_OUT_EN = 7;

  // Field positions in the status register
  localparam int STAT_LVP = 0;
  localparam int STAT_SHUTDOWN = 1;
  localparam int STAT_EXT_INT_LSB = 2;

endpackage

// file: level_sync.sv
// Two-stage synchroniser for a vector of asynchronous pin levels
`timescale 1ns/1ns
module level_sync #(
  parameter int WIDTH = 8
) (
  input wire logic mclk_i,               // Core clock
  input wire logic rst_i,                // Synchronous reset, active high
  input wire logic [WIDTH-1:0] async_i,  // Raw pin levels
  output logic [WIDTH-1:0] sync_o        // Levels safe to use in the core domain
);

  logic [WIDTH-1:0] meta_reg;

  // First stage feeds only the second stage
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      meta_reg <= '0;
      sync_o <= '0;
    end else begin
      meta_reg <= async_i;
      sync_o <= meta_reg;
    end
  end

endmodule

// file: port_c_mux.sv
// Port C: output latch, direction control, analog select and low-pin alternate functions
//
// Local design decisions: the Wishbone slave port and the register offsets.
`timescale 1ns/1ns
module port_c_mux #(
  parameter logic [7:0] LATCH_RESET = port_c_pkg::LATCH_RESET_DEFAULT
) (
  input wire logic mclk_i,                                  // Core clock, 100 MHz
  input wire logic rst_i,                                   // Synchronous reset
  // Classic Wishbone slave
  input wire logic wb_cyc_i,                                // Bus cycle
  input wire logic wb_stb_i,                                // Strobe
  input wire logic wb_we_i,                                 // Write enable
  input wire logic [port_c_pkg::ADDR_WIDTH-1:0] wb_adr_i,   // Byte address
  input wire logic [3:0] wb_sel_i,                          // Byte enables
  input wire logic [port_c_pkg::DATA_WIDTH-1:0] wb_dat_i,   // Write data
  output logic [port_c_pkg::DATA_WIDTH-1:0] wb_dat_o,       // Read data
  output logic wb_ack_o,                                    // Acknowledge
  // Pins
  input wire logic [port_c_pkg::PORT_WIDTH-1:0] pin_in_i,   // Pin levels
  output logic [port_c_pkg::PORT_WIDTH-1:0] pin_out_o,      // Pin drive value
  output logic [port_c_pkg::PORT_WIDTH-1:0] pin_oe_n_o,     // Drive enable, low drives
  // Peripheral side
  input wire logic comparator_result_i,                     // Comparator output level
  input wire logic pwm_channel_b_i,                         // PWM channel B level
  input wire logic pwm_channel_c_i,                         // PWM channel C level
  input wire logic pwm_channel_d_i,                         // PWM channel D level
  input wire logic pwm_shutdown_i,                          // PWM shutdown active
  input wire logic low_voltage_prog_cfg_i,                  // Configuration bit
  output logic program_entry_pin_o,                         // Pin 3 level for entry
  output logic [port_c_pkg::NUM_EXT_INT-1:0] ext_interrupt_o, // Interrupt inputs 0..2
  output logic [port_c_pkg::NUM_CONV_CH-1:0] converter_ch_en_o, // Channels 4..7 usable
  output logic comparator_noninverting_in_en_o,             // Pin 0 to comparator plus
  output logic comparator_inverting_in_1_en_o,              // Pin 1 to comparator minus
  output logic ref_high_in_en_o,                            // Pin 0 as high reference
  output logic ref_low_in_en_o,                             // Pin 1 as low reference
  output logic reference_voltage_out_en_o                   // Reference driven on pin 2
);

  localparam int W = port_c_pkg::PORT_WIDTH;

  // Registered state
  logic [W-1:0] output_latch_c_reg;
  logic [W-1:0] direction_bits_c_reg;
  logic [W-1:0] analog_select_reg;
  logic [W-1:0] alt_ctrl_reg;
  logic ack_reg;
  logic [port_c_pkg::DATA_WIDTH-1:0] rdata_reg;

  // Synchronised pins and derived values
  logic [W-1:0] pin_sync;
  logic [W-1:0] pin_level_c;
  logic [W-1:0] digital_off;
  logic [W-1:0] periph_sel;
  logic [W-1:0] periph_val;
  logic [W-1:0] float_req;
  logic [port_c_pkg::DATA_WIDTH-1:0] rdata_next;
  logic bus_write;

  // Byte-lane merge of the low lane into an 8-bit register
  function automatic logic [7:0] lane_write(
    input logic [7:0] old_val,
    input logic [31:0] data,
    input logic [3:0] sel
  );
    lane_write = sel[0] ? data[7:0] : old_val;
  endfunction

  // Zero-extend an 8-bit register onto the data bus
  function automatic logic [31:0] widen(input logic [7:0] val);
    widen = {24'h00_0000, val};
  endfunction

  // Pin input synchroniser
  level_sync #(
    .WIDTH(W)
  ) u_sync (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .async_i(pin_in_i),
    .sync_o(pin_sync)
  );

  // A write is taken in the cycle before the acknowledge
  assign bus_write = wb_cyc_i && wb_stb_i && wb_we_i && !ack_reg;

  // Output latch; reset value stands in for the unknown power-on state
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      output_latch_c_reg <= LATCH_RESET;
    end else if (bus_write && wb_adr_i == port_c_pkg::OFS_LATCH) begin
      output_latch_c_reg <= lane_write(output_latch_c_reg, wb_dat_i, wb_sel_i);
    end
  end

  // Direction register, all inputs after reset
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      direction_bits_c_reg <= port_c_pkg::DIRECTION_RESET;
    end else if (bus_write && wb_adr_i == port_c_pkg::OFS_DIRECTION) begin
      direction_bits_c_reg <= lane_write(direction_bits_c_reg, wb_dat_i, wb_sel_i);
    end
  end

  // Analog select register, analog pins selected after reset
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      analog_select_reg <= port_c_pkg::ANALOG_SEL_RESET;
    end else if (bus_write && wb_adr_i == port_c_pkg::OFS_ANALOG_SEL) begin
      analog_select_reg <= lane_write(analog_select_reg, wb_dat_i, wb_sel_i);
    end
  end

  // Alternate-function enables
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      alt_ctrl_reg <= port_c_pkg::ALT_CTRL_RESET;
    end else if (bus_write && wb_adr_i == port_c_pkg::OFS_ALT_CTRL) begin
      alt_ctrl_reg <= lane_write(alt_ctrl_reg, wb_dat_i, wb_sel_i);
    end
  end

  // Pins whose whole digital path is switched off
  always_comb begin
    digital_off = '0;
    digital_off[port_c_pkg::PIN_REF_OUT] = alt_ctrl_reg[port_c_pkg::ALT_REF_OUT_EN];
    digital_off[port_c_pkg::PIN_PROG] = low_voltage_prog_cfg_i;
  end

  // Peripheral overrides of the latch data; PWM B wins over the comparator on pin 4
  always_comb begin
    periph_sel = '0;
    periph_val = '0;
    float_req = '0;
    periph_sel[port_c_pkg::PIN_CMP_OUT] = alt_ctrl_reg[port_c_pkg::ALT_CMP_OUT_EN];
    periph_val[port_c_pkg::PIN_CMP_OUT] = comparator_result_i;
    if (alt_ctrl_reg[port_c_pkg::ALT_PWM_B_EN]) begin
      periph_sel[port_c_pkg::PIN_PWM_B] = 1'b1;
      periph_val[port_c_pkg::PIN_PWM_B] = pwm_channel_b_i;
      float_req[port_c_pkg::PIN_PWM_B] = pwm_shutdown_i &&
        alt_ctrl_reg[port_c_pkg::ALT_SHDN_TRI_B];
    end
    if (alt_ctrl_reg[port_c_pkg::ALT_PWM_C_EN]) begin
      periph_sel[port_c_pkg::PIN_PWM_C] = 1'b1;
      periph_val[port_c_pkg::PIN_PWM_C] = pwm_channel_c_i;
      float_req[port_c_pkg::PIN_PWM_C] = pwm_shutdown_i &&
        alt_ctrl_reg[port_c_pkg::ALT_SHDN_TRI_C];
    end
    if (alt_ctrl_reg[port_c_pkg::ALT_PWM_D_EN]) begin
      periph_sel[port_c_pkg::PIN_PWM_D] = 1'b1;
      periph_val[port_c_pkg::PIN_PWM_D] = pwm_channel_d_i;
      float_req[port_c_pkg::PIN_PWM_D] = pwm_shutdown_i &&
        alt_ctrl_reg[port_c_pkg::ALT_SHDN_TRI_D];
    end
  end

  // Pin drivers: combinational from registers, peripheral levels, shutdown and the configuration bit; analog select has no say here
  always_comb begin
    for (int i = 0; i < W; i++) begin
      pin_out_o[i] = periph_sel[i] ? periph_val[i] : output_latch_c_reg[i];
      pin_oe_n_o[i] = direction_bits_c_reg[i] || digital_off[i] || float_req[i];
    end
  end

  // Port read value: analog-selected and disabled pins read 0
  assign pin_level_c = pin_sync & ~analog_select_reg & ~digital_off;

  // External interrupt inputs from pins 0 to 2 when they are inputs, not analog-selected and not disabled
  assign ext_interrupt_o = pin_level_c[port_c_pkg::NUM_EXT_INT-1:0] &
    direction_bits_c_reg[port_c_pkg::NUM_EXT_INT-1:0];

  // Programming entry input is live only with the configuration bit set
  assign program_entry_pin_o = low_voltage_prog_cfg_i &&
    pin_sync[port_c_pkg::PIN_PROG];

  // Analog routing enables; one select bit serves comparator and converter
  always_comb begin
    for (int i = 0; i < port_c_pkg::NUM_CONV_CH; i++) begin
      converter_ch_en_o[i] = analog_select_reg[i] && direction_bits_c_reg[i] &&
        !digital_off[i];
    end
  end

  assign comparator_noninverting_in_en_o =
    converter_ch_en_o[port_c_pkg::PIN_REF_HIGH];
  assign ref_high_in_en_o = converter_ch_en_o[port_c_pkg::PIN_REF_HIGH];
  assign comparator_inverting_in_1_en_o =
    converter_ch_en_o[port_c_pkg::PIN_REF_LOW];
  assign ref_low_in_en_o = converter_ch_en_o[port_c_pkg::PIN_REF_LOW];
  assign reference_voltage_out_en_o = alt_ctrl_reg[port_c_pkg::ALT_REF_OUT_EN];

  // Read multiplexer; unmapped addresses read zero
  always_comb begin
    unique case (wb_adr_i)
      port_c_pkg::OFS_LATCH: rdata_next = widen(output_latch_c_reg);
      port_c_pkg::OFS_DIRECTION: rdata_next = widen(direction_bits_c_reg);
      port_c_pkg::OFS_PIN_LEVEL: rdata_next = widen(pin_level_c);
      port_c_pkg::OFS_ANALOG_SEL: rdata_next = widen(analog_select_reg);
      port_c_pkg::OFS_ALT_CTRL: rdata_next = widen(alt_ctrl_reg);
      port_c_pkg::OFS_STATUS: begin
        rdata_next = port_c_pkg::READ_ZERO;
        rdata_next[port_c_pkg::STAT_LVP] = low_voltage_prog_cfg_i;
        rdata_next[port_c_pkg::STAT_SHUTDOWN] = pwm_shutdown_i;
        rdata_next[port_c_pkg::STAT_EXT_INT_LSB +: port_c_pkg::NUM_EXT_INT] = ext_interrupt_o;
      end
      default: rdata_next = port_c_pkg::READ_ZERO;
    endcase
  end

  // Single-wait-state acknowledge, dropped the cycle after it is given
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      ack_reg <= 1'b0;
      rdata_reg <= port_c_pkg::READ_ZERO;
    end else begin
      ack_reg <= wb_cyc_i && wb_stb_i && !ack_reg;
      rdata_reg <= (wb_cyc_i && wb_stb_i && !wb_we_i && !ack_reg) ?
        rdata_next : port_c_pkg::READ_ZERO;
    end
  end

  assign wb_ack_o = ack_reg;
  assign wb_dat_o = rdata_reg;

endmodule

// file: port_c_asserts.sv
// Concurrent checks on the port C block ports
`timescale 1ns/1ns
module port_c_asserts (
  input wire logic mclk_i, // Core clock
  input wire logic rst_i, // Reset
  input wire logic wb_cyc_i, // Cycle
  input wire logic wb_stb_i, // Strobe
  input wire logic [port_c_pkg::DATA_WIDTH-1:0] wb_dat_o, // Read data
  input wire logic wb_ack_o, // Ack
  input wire logic [port_c_pkg::PORT_WIDTH-1:0] pin_in_i, // Pins
  input wire logic [port_c_pkg::PORT_WIDTH-1:0] pin_oe_n_o, // Drive enables
  input wire logic low_voltage_prog_cfg_i, // Prog cfg
  input wire logic program_entry_pin_o, // Entry level
  input wire logic [port_c_pkg::NUM_EXT_INT-1:0] ext_interrupt_o, // Interrupts
  input wire logic [port_c_pkg::NUM_CONV_CH-1:0] converter_ch_en_o, // Channels
  input wire logic comparator_noninverting_in_en_o, // Cmp plus
  input wire logic comparator_inverting_in_1_en_o, // Cmp minus
  input wire logic ref_high_in_en_o, // Ref high
  input wire logic ref_low_in_en_o, // Ref low
  input wire logic reference_voltage_out_en_o // Ref out
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  // Bus request and answer steps
  sequence req_taken_s; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
  sequence ack_pulse_s; wb_ack_o ##1 !wb_ack_o; endsequence
  bus_answer_a: assert property (req_taken_s |=> ack_pulse_s)
    else $error("ack not a single pulse after request");
  ack_cause_a: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  idle_data_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0000_0000)
    else $error("read data outside ack");
  // Pin checks: reset state, pin 3 with programming entry, pin 2 with reference out, interrupts, analog enables
  reset_state_a: assert property (
    $fell(rst_i) |-> pin_oe_n_o == 8'hFF &&
      converter_ch_en_o == {!low_voltage_prog_cfg_i, 3'h7})
    else $error("wrong state after reset");
  prog_only_a: assert property (
    low_voltage_prog_cfg_i |-> pin_oe_n_o[3] && !converter_ch_en_o[3])
    else $error("pin 3 used while programming entry");
  prog_entry_a: assert property (
    program_entry_pin_o |-> low_voltage_prog_cfg_i && $past(pin_in_i[3], 2))
    else $error("entry level wrong");
  ref_out_a: assert property (
    reference_voltage_out_en_o |-> pin_oe_n_o[2] && !converter_ch_en_o[2])
    else $error("pin 2 digital with reference out");
  ext_int_a: assert property (
    (ext_interrupt_o & ~($past(pin_in_i[2:0], 2) & pin_oe_n_o[2:0])) == 3'h0)
    else $error("interrupt input not from synchronised input pin");
  conv_input_a: assert property ((converter_ch_en_o & ~pin_oe_n_o[3:0]) == 4'h0)
    else $error("converter channel on driven pin");
  high_alias_a: assert property (
    comparator_noninverting_in_en_o == converter_ch_en_o[0] &&
      ref_high_in_en_o == converter_ch_en_o[0])
    else $error("pin 0 analog enables differ");
  low_alias_a: assert property (
    comparator_inverting_in_1_en_o == converter_ch_en_o[1] &&
      ref_low_in_en_o == converter_ch_en_o[1])
    else $error("pin 1 analog enables differ");
endmodule
bind port_c_mux port_c_asserts u_chk (.mclk_i(mclk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .pin_in_i(pin_in_i),
  .pin_oe_n_o(pin_oe_n_o), .low_voltage_prog_cfg_i(low_voltage_prog_cfg_i),
  .program_entry_pin_o(program_entry_pin_o), .ext_interrupt_o(ext_interrupt_o),
  .converter_ch_en_o(converter_ch_en_o), .ref_high_in_en_o(ref_high_in_en_o),
  .comparator_noninverting_in_en_o(comparator_noninverting_in_en_o),
  .comparator_inverting_in_1_en_o(comparator_inverting_in_1_en_o),
  .ref_low_in_en_o(ref_low_in_en_o), .reference_voltage_out_en_o(reference_voltage_out_en_o));

// file: port_c_pin_mux_low_half_test.sv
// Self-checking bench for the port C block
`timescale 1ns/1ns
`define CHK(nm, ex, got) begin checks_done++; if ((got) !== (ex)) begin err_count++; \
  $display("unexpected %s exp %h got %h", nm, ex, got); end end
module port_c_pin_mux_low_half_test;
  logic mclk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, ack, pent, a0, a1, a2, a3, refo;
  logic cmp = 0, pb = 0, pc = 0, pd = 0, sd = 0, low_voltage_prog_cfg = 0;
  logic [7:0] adr = 0, pin_in = 0, pin_out, oe_n;
  logic [3:0] sel = 0, conv;
  logic [2:0] eint;
  logic [31:0] wdat = 0, rdat, rd_o;
  int err_count = 0, checks_done = 0, cycles = 0, lat, dir, ans, alt, a;
  int addrs[7] = '{0, 4, 8, 12, 16, 20, 24};
  port_c_mux u_dut (.mclk_i(mclk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rd_o),
    .wb_ack_o(ack), .pin_in_i(pin_in), .pin_out_o(pin_out), .pin_oe_n_o(oe_n),
    .comparator_result_i(cmp), .pwm_channel_b_i(pb), .pwm_channel_c_i(pc),
    .pwm_channel_d_i(pd), .pwm_shutdown_i(sd), .low_voltage_prog_cfg_i(low_voltage_prog_cfg),
    .program_entry_pin_o(pent), .ext_interrupt_o(eint), .converter_ch_en_o(conv),
    .comparator_noninverting_in_en_o(a0), .comparator_inverting_in_1_en_o(a1),
    .ref_high_in_en_o(a2), .ref_low_in_en_o(a3), .reference_voltage_out_en_o(refo));
  // Clock and hang guard
  always #5 mclk_i = ~mclk_i;
  always @(posedge mclk_i) begin
    cycles++;
    if (cycles == 20000) begin
      err_count++;
      wrap_up();
    end
  end
  // Model: pins whose digital path is taken by reference out or programming entry
  function automatic int dis();
    return (alt[7] << 2) | (low_voltage_prog_cfg << 3);
  endfunction
  function automatic int exp_oe();
    int o;
    o = dir | dis();
    if (sd) o = o | ((alt[4] & alt[1]) << 4) | ((alt[5] & alt[2]) << 3) | ((alt[6] & alt[3]) << 2);
    return o & 255;
  endfunction
  function automatic int exp_out();
    int o;
    o = lat;
    if (alt[0]) o[4] = cmp;
    if (alt[1]) o[4] = pb;
    if (alt[2]) o[3] = pc;
    if (alt[3]) o[2] = pd;
    return o;
  endfunction
  function automatic int exp_eint();
    return pin_in & dir & ~ans & ~dis() & 7;
  endfunction
  function automatic int exp_rd(int ad);
    case (ad)
      0: return lat;
      4: return dir;
      8: return pin_in & ~ans & ~dis() & 255;
      12: return ans;
      16: return alt;
      20: return (exp_eint() << 2) | (sd << 1) | low_voltage_prog_cfg;
      default: return 0;
    endcase
  endfunction
  // One classic bus cycle; the model takes a write at the ack edge
  task wb(input logic w, input logic [7:0] ad, input logic [31:0] d, input logic [3:0] s);
    @(posedge mclk_i);
    cyc <= 1;
    stb <= 1;
    we <= w;
    adr <= ad;
    wdat <= d;
    sel <= s;
    @(posedge mclk_i);
    while (ack !== 1'b1) @(posedge mclk_i);
    rdat = rd_o;
    cyc <= 0;
    stb <= 0;
    if (w && s[0]) begin
      case (ad)
        0: lat = d[7:0];
        4: dir = d[7:0];
        12: ans = d[7:0];
        16: alt = d[7:0];
        default: ;
      endcase
    end
  endtask
  // Let pins settle, compare every output, then read one register
  task check_all(input int ad);
    int cv;
    repeat (3) @(posedge mclk_i);
    cv = ans & dir & ~dis();
    `CHK("oe_n", 8'(exp_oe()), oe_n)
    `CHK("pin_out", 8'(exp_out() & ~exp_oe()), pin_out & ~oe_n)
    `CHK("ext_int", 3'(exp_eint()), eint)
    `CHK("conv", 4'(cv), conv)
    `CHK("cmp_plus", cv[0], a0)
    `CHK("ref_high", cv[0], a2)
    `CHK("cmp_minus", cv[1], a1)
    `CHK("ref_low", cv[1], a3)
    `CHK("entry", low_voltage_prog_cfg & pin_in[3], pent)
    `CHK("ref_out", 1'(alt[7]), refo)
    wb(1'b0, 8'(ad), 32'h0000_0000, 4'hF);
    `CHK("read", 32'(exp_rd(ad)), rdat)
  endtask
  // Reset, and the power-on state of the model
  task reset_dut();
    rst_i <= 1;
    repeat (2) @(posedge mclk_i);
    rst_i <= 0;
    lat = port_c_pkg::LATCH_RESET_DEFAULT;
    dir = port_c_pkg::DIRECTION_RESET;
    ans = port_c_pkg::ANALOG_SEL_RESET;
    alt = port_c_pkg::ALT_CTRL_RESET;
  endtask
  task wrap_up();
    if (err_count == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // Reset values, random traffic, then a second reset
  initial begin
    void'($urandom(32'hff59_626d));
    reset_dut();
    foreach (addrs[i]) check_all(addrs[i]);
    repeat (300) begin
      a = addrs[$urandom_range(6)];
      wb(1'b1, 8'(a), $urandom, 4'($urandom_range(15)));
      {cmp, pb, pc, pd, sd, low_voltage_prog_cfg} <= 6'($urandom);
      pin_in <= 8'($urandom);
      check_all(addrs[$urandom_range(6)]);
    end
    reset_dut();
    foreach (addrs[i]) check_all(addrs[i]);
    wrap_up();
  end
endmodule
